// ### mvvr_pkg.sv
// Package with the coprocessor encodings, field positions and carrier types of the block.
package mvvr_pkg;

    // Coprocessor selector fields of each register in this slice.
    localparam logic [2:0] OP1_STD = 3'h0;
    localparam logic [2:0] OP1_CFG = 3'h4;
    localparam logic [3:0] CRN_VEC = 4'hc;
    localparam logic [3:0] CRN_CTX = 4'hd;
    localparam logic [3:0] CRN_CFG = 4'hf;
    localparam logic [3:0] CRM_C0 = 4'h0;
    localparam logic [3:0] CRM_C1 = 4'h1;
    localparam logic [2:0] OP2_0 = 3'h0;
    localparam logic [2:0] OP2_1 = 3'h1;

    // Field positions.
    localparam int VBASE_LSB = 5;
    localparam int ABORT_BIT = 8;
    localparam int IRQ_BIT = 7;
    localparam int FAST_BIT = 6;
    localparam int TAG_PROC_LSB = 8;

    // Values after reset and fixed read values.
    localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
    localparam logic [31:0] CTX_RESET = 32'h0000_0000;
    localparam logic [2:0] INJECT_RESET = 3'h0;
    localparam logic [31:0] CFG_BASE_VALUE = 32'h0000_0000;

    // Coprocessor move request as seen by the register slice.
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } mvvr_cp_req_t;

    // Answer returned one cycle after a request.
    typedef struct packed {
        logic ack;
        logic undef;
        logic [31:0] rdata;
    } mvvr_cp_rsp_t;

    // One flag each for abort, normal interrupt and fast interrupt, abort in the top bit.
    typedef struct packed {
        logic abort;
        logic irq;
        logic fast;
    } mvvr_exc_t;

endpackage

// ### mvvr_regs.sv
// Monitor vector base, pending status, virtual injection and context tag register slice.
//
// Functional notes
// [R1] Bits 31..5 of monitor_vector_base hold the monitor vector table base.
// [R2] monitor_vector_base is reachable only from Secure state and a privileged mode.
// [R3] Non-secure with override and to-monitor set reports virtual, else physical pending.
// [R4] Virtual pending stays reported until its inject request bit clears: by software, or for abort by taking it.
// [R5] pending_status bit 8 shows a pending external abort.
// [R6] pending_status bit 7 shows a pending normal interrupt.
// [R7] pending_status bit 6 shows a pending fast interrupt.
// [R8] pending_status is one read-only register for both states; bits 31..9 zero.
// [R9] Inject bit 8 pends a virtual abort only with to-monitor and override set.
// [R10] Inject bit 7 pends a virtual interrupt only with to-monitor and override set.
// [R11] Inject bit 6 pends a virtual fast interrupt only with to-monitor and override.
// [R12] Virtual exceptions are taken only in Non-secure state with the mask clear.
// [R13] Taking a virtual abort clears its inject request bit in hardware.
// [R14] Taking a virtual interrupt leaves its inject request bit to software.
// [R15] Wake from wait instructions counts virtual pending like physical pending.
// [R16] inject_pending_ctrl bits 31..9 and 5..0 read zero and ignore writes.
// [R17] running_context_tag holds process tag 31..8 and address-space tag 7..0.
// [R18] The whole running_context_tag goes out as the debug and trace context.
// [R19] config_base_addr always reads zero.
// [R20] Every register here is reachable only from privileged modes.
// [R21] Disallowed accesses answer with an undefined-instruction indication.
`timescale 1ns/1ps
module mvvr_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mvvr_pkg::mvvr_cp_req_t cp_req,
    output mvvr_pkg::mvvr_cp_rsp_t cp_rsp,
    input wire logic secure_state,
    input wire logic privileged,
    input wire mvvr_pkg::mvvr_exc_t to_monitor,
    input wire mvvr_pkg::mvvr_exc_t override_ctrl,
    input wire mvvr_pkg::mvvr_exc_t psw_mask,
    input wire mvvr_pkg::mvvr_exc_t phys_pending_pin,
    input wire logic virt_abort_taken,
    output mvvr_pkg::mvvr_exc_t virt_take,
    output logic wake_request,
    output logic [31:0] context_id,
    output logic [31:0] vector_base
);

    logic [2:0] phys_meta;
    mvvr_pkg::mvvr_exc_t phys_pending;
    mvvr_pkg::mvvr_exc_t inject_req;
    mvvr_pkg::mvvr_exc_t virt_pending;
    mvvr_pkg::mvvr_exc_t use_virt;
    mvvr_pkg::mvvr_exc_t shown;
    logic [31:0] vbase;
    logic [31:0] ctx_tag;
    logic sel_vbase;
    logic sel_status;
    logic sel_inject;
    logic sel_ctx;
    logic sel_cfg;
    logic hit;
    logic allowed;
    logic wr_ok;
    logic [31:0] next_rdata;
    logic [31:0] status_word;
    logic [31:0] inject_word;

    // Pending pins come from outside the core clock, so they pass two flops first.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phys_meta <= 3'h0;
            phys_pending <= '0;
        end else begin
            phys_meta <= phys_pending_pin;
            phys_pending <= phys_meta;
        end
    end

    // Register selection from the coprocessor selector fields.
    always_comb begin
        sel_vbase = cp_req.opc1 == mvvr_pkg::OP1_STD && cp_req.crn == mvvr_pkg::CRN_VEC
            && cp_req.crm == mvvr_pkg::CRM_C0 && cp_req.opc2 == mvvr_pkg::OP2_1;
        sel_status = cp_req.opc1 == mvvr_pkg::OP1_STD && cp_req.crn == mvvr_pkg::CRN_VEC
            && cp_req.crm == mvvr_pkg::CRM_C1 && cp_req.opc2 == mvvr_pkg::OP2_0;
        sel_inject = cp_req.opc1 == mvvr_pkg::OP1_STD && cp_req.crn == mvvr_pkg::CRN_VEC
            && cp_req.crm == mvvr_pkg::CRM_C1 && cp_req.opc2 == mvvr_pkg::OP2_1;
        sel_ctx = cp_req.opc1 == mvvr_pkg::OP1_STD && cp_req.crn == mvvr_pkg::CRN_CTX
            && cp_req.crm == mvvr_pkg::CRM_C0 && cp_req.opc2 == mvvr_pkg::OP2_1;
        sel_cfg = cp_req.opc1 == mvvr_pkg::OP1_CFG && cp_req.crn == mvvr_pkg::CRN_CFG
            && cp_req.crm == mvvr_pkg::CRM_C0 && cp_req.opc2 == mvvr_pkg::OP2_0;
        hit = sel_vbase | sel_status | sel_inject | sel_ctx | sel_cfg;
    end

    // Privilege gates everything, Secure state additionally gates the vector base.
    // Writes to the read-only registers are refused the same way as a bad mode.
    always_comb begin
        allowed = privileged && (!sel_vbase || secure_state); // [R2] [R20]
        if (cp_req.write && (sel_status || sel_cfg)) begin
            allowed = 1'b0;
        end
        wr_ok = cp_req.valid && cp_req.write && hit && allowed;
    end

    // Virtual pending needs the inject bit plus both routing controls.
    always_comb begin
        virt_pending = inject_req & to_monitor & override_ctrl; // [R9] [R10] [R11]
        use_virt = (secure_state ? 3'h0 : 3'h7) & to_monitor & override_ctrl; // [R3]
        shown = (use_virt & virt_pending) | (~use_virt & phys_pending); // [R3] [R4]
    end

    // Status and inject words with every reserved bit forced to zero.
    always_comb begin
        status_word = 32'h0000_0000; // [R8]
        status_word[mvvr_pkg::ABORT_BIT] = shown.abort; // [R5]
        status_word[mvvr_pkg::IRQ_BIT] = shown.irq; // [R6]
        status_word[mvvr_pkg::FAST_BIT] = shown.fast; // [R7]
        inject_word = 32'h0000_0000; // [R16]
        inject_word[mvvr_pkg::ABORT_BIT] = inject_req.abort;
        inject_word[mvvr_pkg::IRQ_BIT] = inject_req.irq;
        inject_word[mvvr_pkg::FAST_BIT] = inject_req.fast;
    end

    // Read data mux; the low reserved bits of the vector base read as zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (sel_vbase) begin
            next_rdata = vbase;
        end else if (sel_status) begin
            next_rdata = status_word;
        end else if (sel_inject) begin
            next_rdata = inject_word;
        end else if (sel_ctx) begin
            next_rdata = ctx_tag;
        end else if (sel_cfg) begin
            next_rdata = mvvr_pkg::CFG_BASE_VALUE; // [R19]
        end
    end

    // Answer one cycle after the request; refused or unmapped accesses flag undef.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cp_rsp <= '0;
        end else begin
            cp_rsp.ack <= cp_req.valid;
            cp_rsp.undef <= cp_req.valid && !(hit && allowed); // [R21]
            if (cp_req.valid && !cp_req.write && hit && allowed) begin
                cp_rsp.rdata <= next_rdata;
            end else begin
                cp_rsp.rdata <= 32'h0000_0000;
            end
        end
    end

    // Vector base keeps only bits 31..5; the reserved low bits are not stored.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vbase <= mvvr_pkg::VBASE_RESET;
        end else if (wr_ok && sel_vbase) begin
            vbase <= {cp_req.wdata[31:mvvr_pkg::VBASE_LSB], 5'h00}; // [R1]
        end
    end

    // Context tag is stored whole; software keeps the process tag unique.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctx_tag <= mvvr_pkg::CTX_RESET;
        end else if (wr_ok && sel_ctx) begin
            ctx_tag <= cp_req.wdata; // [R17]
        end
    end

    // Inject requests: a taken virtual abort clears its bit, but a software write in
    // the same cycle wins so a freshly written request is never lost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inject_req <= mvvr_pkg::INJECT_RESET;
        end else if (wr_ok && sel_inject) begin
            inject_req.abort <= cp_req.wdata[mvvr_pkg::ABORT_BIT];
            inject_req.irq <= cp_req.wdata[mvvr_pkg::IRQ_BIT];
            inject_req.fast <= cp_req.wdata[mvvr_pkg::FAST_BIT]; // [R16]
        end else if (virt_abort_taken) begin
            inject_req.abort <= 1'b0; // [R13] [R14]
        end
    end

    // Take requests to the core: Non-secure only and with the status mask clear.
    always_comb begin
        virt_take = secure_state ? 3'h0 : (virt_pending & ~psw_mask); // [R12]
    end

    // Wait instructions wake on physical or virtual pending alike.
    assign wake_request = |(phys_pending | virt_pending); // [R15]
    assign context_id = ctx_tag; // [R18]
    assign vector_base = vbase;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_vbase_write_keeps: assert property ( // [R1]
        wr_ok && sel_vbase |=> vector_base == {$past(cp_req.wdata[31:5]), 5'h00})
        else $error("vector base did not take the written bits 31..5");

    a_vbase_secure_only: assert property ( // [R2]
        cp_req.valid && sel_vbase && !secure_state |=> cp_rsp.undef && $stable(vector_base))
        else $error("non-secure access to vector base was not refused");

    a_status_routing: assert property ( // [R3]
        !secure_state && to_monitor.irq && override_ctrl.irq
            |-> shown.irq == inject_req.irq)
        else $error("status did not report the virtual interrupt");

    a_status_read_word: assert property ( // [R5]
        cp_req.valid && !cp_req.write && sel_status && privileged
            |=> cp_rsp.rdata == {23'h0, $past(shown), 6'h00})
        else $error("status read returned wrong bits");

    a_virt_abort_gate: assert property ( // [R9]
        virt_pending.abort |-> inject_req.abort && to_monitor.abort && override_ctrl.abort)
        else $error("virtual abort pending without both controls set");

    a_take_secure_block: assert property ( // [R12]
        secure_state |-> virt_take == 3'h0)
        else $error("virtual exception taken in secure state");

    a_abort_auto_clear: assert property ( // [R13]
        virt_abort_taken && !(wr_ok && sel_inject) |=> !inject_req.abort)
        else $error("taken virtual abort did not clear its request");

    a_irq_kept_on_take: assert property ( // [R14]
        virt_take.irq && !(wr_ok && sel_inject) |=> inject_req.irq)
        else $error("interrupt request changed without a write");

    a_wake_on_virtual: assert property ( // [R15]
        virt_pending != 3'h0 |-> wake_request)
        else $error("virtual pending did not wake the core");

    a_cfg_reads_zero: assert property ( // [R19]
        cp_req.valid && !cp_req.write && sel_cfg |=> cp_rsp.ack && cp_rsp.rdata == 32'h0)
        else $error("config base read was not zero");

    a_user_refused: assert property ( // [R20]
        cp_req.valid && !privileged |=> cp_rsp.ack && cp_rsp.undef && cp_rsp.rdata == 32'h0000_0000)
        else $error("unprivileged access was not refused");

    // Answer timing: exactly one answer, one cycle after each request, and none otherwise.
    a_ack_next_cycle: assert property ( // [R21]
        cp_req.valid |=> cp_rsp.ack)
        else $error("request was not answered in the next cycle");

    a_no_spurious_answer: assert property ( // [R21]
        !cp_req.valid |=> !cp_rsp.ack && !cp_rsp.undef)
        else $error("answer appeared without a request");

    // Unprivileged writes must leave the context tag and the vector base untouched.
    a_refused_write_inert: assert property ( // [R20]
        cp_req.valid && cp_req.write && !privileged |=> $stable(context_id) && $stable(vector_base))
        else $error("unprivileged write changed a register");

    a_ro_write_refused: assert property ( // [R21]
        cp_req.valid && cp_req.write && (sel_status || sel_cfg) |=> cp_rsp.undef)
        else $error("write to a read-only register was not refused");

    a_unmapped_refused: assert property ( // [R21]
        cp_req.valid && !hit |=> cp_rsp.undef && cp_rsp.rdata == 32'h0000_0000)
        else $error("unmapped selector was not refused");

    a_status_physical: assert property ( // [R3]
        secure_state |-> shown == phys_pending)
        else $error("secure state status did not show physical pending");

    a_status_reserved: assert property ( // [R8]
        cp_req.valid && !cp_req.write && sel_status
            |=> cp_rsp.rdata[31:9] == 23'h0 && cp_rsp.rdata[5:0] == 6'h00)
        else $error("status reserved bits were not zero");

    a_pending_held: assert property ( // [R4]
        !secure_state && to_monitor.irq && override_ctrl.irq && inject_req.irq |-> shown.irq)
        else $error("virtual interrupt dropped from status while requested");

    a_virt_irq_gate: assert property ( // [R10]
        virt_pending.irq |-> inject_req.irq && to_monitor.irq && override_ctrl.irq)
        else $error("virtual interrupt pending without both controls set");

    a_virt_fast_gate: assert property ( // [R11]
        virt_pending.fast |-> inject_req.fast && to_monitor.fast && override_ctrl.fast)
        else $error("virtual fast interrupt pending without both controls set");

    a_inject_reserved: assert property ( // [R16]
        cp_req.valid && !cp_req.write && sel_inject
            |=> cp_rsp.rdata[31:9] == 23'h0 && cp_rsp.rdata[5:0] == 6'h00)
        else $error("inject reserved bits were not zero");

    a_inject_write_takes: assert property ( // [R16]
        wr_ok && sel_inject |=> inject_req == $past(cp_req.wdata[8:6]))
        else $error("inject write did not store bits 8..6");

    a_ctx_write_whole: assert property ( // [R17]
        wr_ok && sel_ctx |=> context_id == $past(cp_req.wdata))
        else $error("context tag write was not stored whole");

    a_take_needs_mask: assert property ( // [R12]
        virt_take != 3'h0 |-> !secure_state && (virt_take & psw_mask) == 3'h0)
        else $error("virtual exception offered while masked or secure");

    a_wake_on_physical: assert property ( // [R15]
        phys_pending != 3'h0 |-> wake_request)
        else $error("physical pending did not wake the core");

    a_fast_kept_taken: assert property ( // [R14]
        virt_take.fast && !(wr_ok && sel_inject) |=> inject_req.fast)
        else $error("fast interrupt request changed without a write");

    // The pins are seen two edges late; the first edges after reset are skipped.
    a_phys_sync_delay: assert property ( // [R3]
        !$past(rst, 2) |-> phys_pending == $past(phys_pending_pin, 2))
        else $error("physical pending did not follow the pins by two edges");

endmodule

// ### mvvr_regs_tb.sv
// Self-checking testbench for the monitor vector and virtual interrupt register slice.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module mvvr_regs_tb;
    localparam logic [13:0] S_VEC = {3'h0, 4'hc, 4'h0, 3'h1};
    localparam logic [13:0] S_STS = {3'h0, 4'hc, 4'h1, 3'h0};
    localparam logic [13:0] S_INJ = {3'h0, 4'hc, 4'h1, 3'h1};
    localparam logic [13:0] S_CTX = {3'h0, 4'hd, 4'h0, 3'h1};
    localparam logic [13:0] S_CFG = {3'h4, 4'hf, 4'h0, 3'h0};
    localparam logic [13:0] S_BAD = {3'h0, 4'h1, 4'h0, 3'h0};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    mvvr_pkg::mvvr_cp_req_t cp_req = '0;
    mvvr_pkg::mvvr_cp_rsp_t cp_rsp;
    logic secure_state = 1'b1;
    logic privileged = 1'b1;
    mvvr_pkg::mvvr_exc_t to_monitor = '0;
    mvvr_pkg::mvvr_exc_t override_ctrl = '0;
    mvvr_pkg::mvvr_exc_t psw_mask = '0;
    mvvr_pkg::mvvr_exc_t phys_pending_pin = '0;
    logic virt_abort_taken = 1'b0;
    mvvr_pkg::mvvr_exc_t virt_take;
    logic wake_request;
    logic [31:0] context_id;
    logic [31:0] vector_base;
    int fails = 0;
    int check_count = 0;

    mvvr_regs i_dut (.clk_sys(clk_sys), .rst(rst), .cp_req(cp_req), .cp_rsp(cp_rsp),
        .secure_state(secure_state), .privileged(privileged), .to_monitor(to_monitor),
        .override_ctrl(override_ctrl), .psw_mask(psw_mask), .phys_pending_pin(phys_pending_pin),
        .virt_abort_taken(virt_abort_taken), .virt_take(virt_take), .wake_request(wake_request),
        .context_id(context_id), .vector_base(vector_base));

    // The core clock at 125 MHz.
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Status word with abort, irq and fast flags in bits 8, 7 and 6.
    function automatic logic [31:0] st(input logic [2:0] v);
        return {23'h0, v, 6'h0};
    endfunction

    // One coprocessor move; the answer stands for exactly one cycle, so it is sampled then.
    // It returns on a rising edge so that callers change inputs on the clock edge.
    task automatic acc(input logic wr, input logic [13:0] sel, input logic [31:0] wd,
                       input logic [31:0] erd, input logic eud);
        @(posedge clk_sys);
        cp_req <= {1'b1, wr, sel, wd};
        @(posedge clk_sys);
        cp_req <= '0;
        #1;
        `CHK("ack", 1'b1, cp_rsp.ack)
        `CHK("undef", eud, cp_rsp.undef)
        `CHK("rdata", erd, cp_rsp.rdata)
        @(posedge clk_sys);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_reset();
        `CHK("vector_base", 32'h0000_0000, vector_base)
        `CHK("context_id", 32'h0000_0000, context_id)
        `CHK("wake_request", 1'b0, wake_request)
        acc(1'b0, S_INJ, 32'h0000_0000, 32'h0000_0000, 1'b0);
        acc(1'b0, S_STS, 32'h0000_0000, 32'h0000_0000, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_vector();
        acc(1'b1, S_VEC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        acc(1'b0, S_VEC, 32'h0000_0000, 32'hFFFF_FFE0, 1'b0);
        `CHK("vector_base", 32'hFFFF_FFE0, vector_base)
        secure_state <= 1'b0;
        acc(1'b0, S_VEC, 32'h0000_0000, 32'h0000_0000, 1'b1);
        acc(1'b1, S_VEC, 32'h0000_0000, 32'h0000_0000, 1'b1);
        secure_state <= 1'b1;
        acc(1'b0, S_VEC, 32'h0000_0000, 32'hFFFF_FFE0, 1'b0);
        $display("test vector done");
    endtask

    task automatic t_context();
        acc(1'b1, S_CTX, 32'h1234_5678, 32'h0000_0000, 1'b0);
        `CHK("context_id", 32'h1234_5678, context_id)
        acc(1'b0, S_CTX, 32'h0000_0000, 32'h1234_5678, 1'b0);
        privileged <= 1'b0;
        acc(1'b0, S_CTX, 32'h0000_0000, 32'h0000_0000, 1'b1);
        acc(1'b1, S_CTX, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        privileged <= 1'b1;
        acc(1'b0, S_CTX, 32'h0000_0000, 32'h1234_5678, 1'b0);
        acc(1'b0, S_CFG, 32'h0000_0000, 32'h0000_0000, 1'b0);
        acc(1'b1, S_CFG, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        acc(1'b1, S_STS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        acc(1'b0, S_BAD, 32'h0000_0000, 32'h0000_0000, 1'b1);
        $display("test context done");
    endtask

    // Physical pins pass a two-flop synchroniser, so three edges are allowed before reading.
    task automatic t_physical();
        phys_pending_pin <= 3'b101;
        repeat (3) @(posedge clk_sys);
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b101), 1'b0);
        phys_pending_pin <= 3'b010;
        repeat (3) @(posedge clk_sys);
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b010), 1'b0);
        `CHK("wake_request", 1'b1, wake_request)
        phys_pending_pin <= 3'b000;
        repeat (3) @(posedge clk_sys);
        $display("test physical done");
    endtask

    task automatic t_virtual();
        to_monitor <= 3'b111;
        override_ctrl <= 3'b111;
        acc(1'b1, S_INJ, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        acc(1'b0, S_INJ, 32'h0000_0000, 32'h0000_01C0, 1'b0);
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b000), 1'b0);
        `CHK("virt_take", 3'b000, virt_take)
        secure_state <= 1'b0;
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b111), 1'b0);
        `CHK("virt_take", 3'b111, virt_take)
        `CHK("wake_request", 1'b1, wake_request)
        psw_mask <= 3'b101;
        override_ctrl <= 3'b011;
        @(posedge clk_sys);
        #1;
        `CHK("virt_take", 3'b010, virt_take)
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b011), 1'b0);
        override_ctrl <= 3'b111;
        psw_mask <= 3'b000;
        virt_abort_taken <= 1'b1;
        @(posedge clk_sys);
        virt_abort_taken <= 1'b0;
        acc(1'b0, S_INJ, 32'h0000_0000, 32'h0000_00C0, 1'b0);
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b011), 1'b0);
        acc(1'b1, S_INJ, 32'h0000_0000, 32'h0000_0000, 1'b0);
        acc(1'b0, S_STS, 32'h0000_0000, st(3'b000), 1'b0);
        `CHK("wake_request", 1'b0, wake_request)
        secure_state <= 1'b1;
        $display("test virtual done");
    endtask

    // A hang is cut short well beyond the roughly one hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_vector();
        t_context();
        t_physical();
        t_virtual();
        end_of_test();
    end
endmodule
